// file: src/fscp_regs.v
/*
 * Status and configuration register bank of a serial flash: power state,
 * busy/latch/error flags, protect level and lockable configuration bits.
 * Assumes a classic Wishbone master on clk; chip select and write-protect
 * come from the SPI side asynchronously; op results come from the array
 * engine as levels sampled at completion.
 */
`timescale 1ns/1ps
`include "fscp_defines.vh"

module fscp_regs #(
  parameter [15:0] OP_CYCLES = `FSCP_OP_CYCLES,
  parameter UNIFORM_256K = 0,
  parameter [2:0] BP_RETAINED = 3'h0
) (
  // system
  input wire clk,
  input wire rst,
  // wishbone slave
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [3:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output wire wb_ack_o,
  output wire wb_err_o,
  // flash pins, asynchronous
  input wire chip_select_n_pin,
  input wire write_protect_n_pin,
  // array engine results at operation end
  input wire erase_fail_in,
  input wire prog_fail_in,
  // derived controls
  output reg [1:0] power_state,
  output wire quad_pinout,
  output wire wp_pin_active,
  output wire pause_pin_active,
  output wire param_sector_at_top,
  output wire protect_from_bottom,
  output wire [2:0] protect_level_bits,
  output reg [23:0] protect_base,
  output reg [24:0] protect_size
);

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  reg cs_meta;
  reg cs_sync;
  reg wp_meta;
  reg wp_sync;
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      cs_meta <= 1'b1;
      cs_sync <= 1'b1;
      wp_meta <= 1'b1;
      wp_sync <= 1'b1;
    end else begin
      cs_meta <= chip_select_n_pin;
      cs_sync <= cs_meta;
      wp_meta <= write_protect_n_pin;
      wp_sync <= wp_meta;
    end
  end

  // ****************************************************************
  // bus decode
  // ****************************************************************
  reg ack;
  wire req = wb_cyc_i & wb_stb_i & ~ack;
  wire wr = req & wb_we_i & wb_sel_i[0];
  wire hit = (wb_adr_i == `FSCP_ADR_STATUS) | (wb_adr_i == `FSCP_ADR_CONFIG) |
             (wb_adr_i == `FSCP_ADR_CMD) | (wb_adr_i == `FSCP_ADR_POWER);
  assign wb_ack_o = ack & hit;
  assign wb_err_o = ack & ~hit;

  // ****************************************************************
  // state
  // ****************************************************************
  reg busy;
  reg write_enable_latch;
  reg [2:0] bp;
  reg erase_err;
  reg prog_err;
  reg status_lock_bit;
  reg [7:0] cfg;
  reg deep;
  reg [15:0] op_cnt;
  reg [1:0] op_kind;
  reg [7:0] wrr_st;
  reg [7:0] wrr_cf;

  localparam [1:0] OP_REG = 2'h0;
  localparam [1:0] OP_PROG = 2'h1;
  localparam [1:0] OP_ERASE = 2'h2;

  wire freeze = cfg[`FSCP_CF_FREEZE];
  assign quad_pinout = cfg[`FSCP_CF_QUAD];
  // quad reuses both pins as data, so their own functions go idle
  assign wp_pin_active = ~quad_pinout;
  assign pause_pin_active = ~quad_pinout;
  assign param_sector_at_top = (UNIFORM_256K == 0) & cfg[`FSCP_CF_PARAM_TOP];
  assign protect_from_bottom = cfg[`FSCP_CF_PROT_BOT];
  assign protect_level_bits = bp;

  // wp pin has no meaning in quad mode, so it never locks there
  wire hw_protect = status_lock_bit & ~wp_sync & wp_pin_active;
  wire op_done = busy & (op_cnt == 16'h0001);

  wire [7:0] cmd = wb_dat_i[7:0];
  wire is_cmd = wr & (wb_adr_i == `FSCP_ADR_CMD);
  wire start_ok = ~busy & write_enable_latch & ~deep;
  // program/erase dropped while asleep
  wire go_prog = is_cmd & (cmd[3:0] == `FSCP_CMD_PROG) & start_ok;
  wire go_erase = is_cmd & (cmd[3:0] == `FSCP_CMD_ERASE) & start_ok;
  wire go_wrr_st = wr & (wb_adr_i == `FSCP_ADR_STATUS) & start_ok;
  wire go_wrr_cf = wr & (wb_adr_i == `FSCP_ADR_CONFIG) & start_ok;

  // ****************************************************************
  // masked write values
  // ****************************************************************
  reg [7:0] next_cfg;
  reg [2:0] next_bp;
  reg next_status_lock_bit;
  always @* begin
    next_cfg = cfg;
    if (!freeze) begin
      next_cfg = wrr_cf & `FSCP_CF_USED;
      if (UNIFORM_256K != 0)
        next_cfg[`FSCP_CF_PARAM_TOP] = 1'b0;
    end
    // one-time bits only ever go up
    next_cfg[`FSCP_CF_PARAM_TOP] = next_cfg[`FSCP_CF_PARAM_TOP] | cfg[`FSCP_CF_PARAM_TOP];
    next_cfg[`FSCP_CF_BP_VOL] = next_cfg[`FSCP_CF_BP_VOL] | cfg[`FSCP_CF_BP_VOL];
    next_cfg[`FSCP_CF_PROT_BOT] = next_cfg[`FSCP_CF_PROT_BOT] | cfg[`FSCP_CF_PROT_BOT];
    next_cfg[`FSCP_CF_FREEZE] = next_cfg[`FSCP_CF_FREEZE] | freeze;
    next_bp = bp;
    next_status_lock_bit = status_lock_bit;
    if (!hw_protect) begin
      next_status_lock_bit = wrr_st[`FSCP_ST_LOCK];
      if (!freeze)
        next_bp = wrr_st[`FSCP_ST_BP_LO+2:`FSCP_ST_BP_LO];
    end
  end

  // ****************************************************************
  // power-on load of protect level
  // ****************************************************************
  // reset cannot read ports, so the power-on level is loaded just after release
  reg por_done;
  always @(posedge clk or posedge rst) begin
    if (rst)
      por_done <= 1'b0;
    else
      por_done <= 1'b1;
  end
  wire load_bp = ~por_done;
  wire [2:0] bp_at_power = cfg[`FSCP_CF_BP_VOL] ? `FSCP_BP_ALL : BP_RETAINED;

  // ****************************************************************
  // operation sequencer and flags
  // ****************************************************************
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      busy <= 1'b0;
      write_enable_latch <= 1'b0;
      bp <= 3'h0;
      erase_err <= 1'b0;
      prog_err <= 1'b0;
      status_lock_bit <= 1'b0;
      cfg <= `FSCP_CF_RESET;
      deep <= 1'b0;
      op_cnt <= 16'h0000;
      op_kind <= OP_REG;
      wrr_st <= 8'h00;
      wrr_cf <= 8'h00;
    end else begin
      if (op_done) begin
        busy <= 1'b0;
        write_enable_latch <= 1'b0;
        op_cnt <= 16'h0000;
        case (op_kind)
          OP_PROG: prog_err <= prog_fail_in;
          OP_ERASE: erase_err <= erase_fail_in;
          default: begin
            cfg <= next_cfg;
            bp <= next_bp;
            status_lock_bit <= next_status_lock_bit;
          end
        endcase
      end else if (busy) begin
        op_cnt <= op_cnt - 16'h0001;
      end else if (go_prog | go_erase | go_wrr_st | go_wrr_cf) begin
        busy <= 1'b1;
        op_cnt <= OP_CYCLES;
        op_kind <= go_prog ? OP_PROG : (go_erase ? OP_ERASE : OP_REG);
        wrr_st <= go_wrr_st ? wb_dat_i[7:0] : {status_lock_bit, 1'b0, 1'b0, bp, 2'h0};
        wrr_cf <= go_wrr_cf ? wb_dat_i[7:0] : cfg;
      end else if (is_cmd) begin
        case (cmd[3:0])
          `FSCP_CMD_WRITE_ENABLE_COMMAND: write_enable_latch <= ~deep;
          `FSCP_CMD_WRDI: write_enable_latch <= 1'b0;
          `FSCP_CMD_SLEEP: deep <= 1'b1;
          `FSCP_CMD_WAKE: deep <= 1'b0;
          default: write_enable_latch <= write_enable_latch;
        endcase
      end
      // no operation can be running on the first edge after release
      if (load_bp)
        bp <= bp_at_power;
    end
  end

  // ****************************************************************
  // power state
  // ****************************************************************
  always @(posedge clk or posedge rst) begin
    if (rst)
      power_state <= `FSCP_PWR_STANDBY;
    else if (!cs_sync)
      power_state <= `FSCP_PWR_ACTIVE;
    else if (busy)
      power_state <= `FSCP_PWR_ACTIVE;
    else if (deep)
      power_state <= `FSCP_PWR_DEEP;
    else
      power_state <= `FSCP_PWR_STANDBY;
  end

  // ****************************************************************
  // protected range
  // ****************************************************************
  reg [24:0] next_size;
  always @* begin
    case (bp)
      3'h0: next_size = 25'h0000000;
      3'h7: next_size = 25'h1000000;
      default: next_size = 25'h0040000 << (bp - 3'h1);
    endcase
  end
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      protect_base <= 24'h000000;
      protect_size <= 25'h0000000;
    end else begin
      protect_size <= next_size;
      protect_base <= protect_from_bottom ? 24'h000000 :
                      (next_size[24] ? 24'h000000 : (24'h000000 - next_size[23:0]));
    end
  end

  // ****************************************************************
  // read data and ack
  // ****************************************************************
  // register reads depend on quad pin-out through the quad bit in the config register and through hw_protect in the power register
  reg [31:0] rd;
  always @* begin
    case (wb_adr_i)
      `FSCP_ADR_STATUS: rd = {24'h000000, status_lock_bit, prog_err, erase_err, bp, write_enable_latch, busy};
      `FSCP_ADR_CONFIG: rd = {24'h000000, cfg};
      `FSCP_ADR_POWER: rd = {29'h00000000, hw_protect, power_state};
      default: rd = 32'h00000000;
    endcase
  end
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      ack <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      ack <= req;
      wb_dat_o <= req ? rd : 32'h00000000;
    end
  end

endmodule // fscp_regs

// file: common/fscp_defines.vh
/*
 * Constants of the flash status/configuration/protection register bank.
 * Assumes a classic Wishbone slave with 32-bit data and byte addresses.
 */
// ****************************************************************
// ****************************************************************
`ifndef FSCP_DEFINES_VH
`define FSCP_DEFINES_VH

// register byte addresses
`define FSCP_ADR_STATUS 4'h0
`define FSCP_ADR_CONFIG 4'h4
`define FSCP_ADR_CMD 4'h8
`define FSCP_ADR_POWER 4'hC

// status field positions
`define FSCP_ST_BUSY 0
`define FSCP_ST_WEL 1
`define FSCP_ST_BP_LO 2
`define FSCP_ST_ERASE_ERR 5
`define FSCP_ST_PROG_ERR 6
`define FSCP_ST_LOCK 7

// configuration field positions
`define FSCP_CF_FREEZE 0
`define FSCP_CF_QUAD 1
`define FSCP_CF_PARAM_TOP 2
`define FSCP_CF_BP_VOL 3
`define FSCP_CF_PROT_BOT 5
`define FSCP_CF_USED 8'h2F
`define FSCP_CF_RESET 8'h00

// command codes written to the command register
`define FSCP_CMD_WRITE_ENABLE_COMMAND 4'h1
`define FSCP_CMD_WRDI 4'h2
`define FSCP_CMD_WRR 4'h3
`define FSCP_CMD_PROG 4'h4
`define FSCP_CMD_ERASE 4'h5
`define FSCP_CMD_SLEEP 4'h6
`define FSCP_CMD_WAKE 4'h7

// power state codes
`define FSCP_PWR_STANDBY 2'h0
`define FSCP_PWR_ACTIVE 2'h1
`define FSCP_PWR_DEEP 2'h2

// internal operation length in clk cycles, and the protect level that covers the whole array
`define FSCP_OP_CYCLES 16'h0040
`define FSCP_BP_ALL 3'h7

`endif

// file: test/fscp_regs_properties.sv
/* Port checker of the flash register bank.
   Bound to fscp_regs below; sees only its ports. */
`timescale 1ns/1ps
module fscp_chk (
  // system
  input wire clk,
  input wire rst,
  // bus
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_ack_o,
  input wire wb_err_o,
  // pins and controls
  input wire chip_select_n_pin,
  input wire [1:0] power_state,
  input wire quad_pinout,
  input wire wp_pin_active,
  input wire param_sector_at_top,
  input wire protect_from_bottom,
  input wire [2:0] protect_level_bits,
  input wire [23:0] protect_base,
  input wire [24:0] protect_size
);
  wire [2:0] b = protect_level_bits;
  wire [24:0] sz = (b == 3'h7) ? 25'h1000000 : (b == 3'h0) ? 25'h0 : (25'h20000 << b);
  wire [24:0] top = 25'h1000000 - sz;
  wire [23:0] bs = protect_from_bottom ? 24'h0 : top[23:0];
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  property p_rng; 1'b1 |=> protect_size == $past(sz) && protect_base == $past(bs); endproperty
  a_rng: assert property (p_rng) else $error("bad range");
  property p_cs; !chip_select_n_pin [*5] |-> power_state != 2'h0; endproperty
  a_cs: assert property (p_cs) else $error("standby while selected");
  property p_quad; wp_pin_active == !quad_pinout; endproperty
  a_quad: assert property (p_quad) else $error("pin use");
  property p_bot; protect_from_bottom |=> protect_from_bottom; endproperty
  a_bot: assert property (p_bot) else $error("direction fell");
  property p_top; param_sector_at_top |=> param_sector_at_top; endproperty
  a_top: assert property (p_top) else $error("location fell");
  property p_deep;
    power_state == 2'h2 && !wb_cyc_i && !$past(wb_cyc_i) && chip_select_n_pin &&
      $past(chip_select_n_pin) && $past(chip_select_n_pin, 2) |=> power_state == 2'h2;
  endproperty
  a_deep: assert property (p_deep) else $error("left deep sleep");
  property p_ack; wb_ack_o || wb_err_o |=> !wb_ack_o && !wb_err_o; endproperty
  a_ack: assert property (p_ack) else $error("long ack");
  property p_ans; wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o |=> wb_ack_o != wb_err_o; endproperty
  a_ans: assert property (p_ans) else $error("no answer");
  c_deep: cover property (power_state == 2'h2);
  c_ends: cover property (protect_from_bottom && param_sector_at_top);
  c_err: cover property (wb_err_o);
endmodule // fscp_chk
bind fscp_regs fscp_chk chk (.clk, .rst, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .wb_err_o,
  .chip_select_n_pin, .power_state, .quad_pinout, .wp_pin_active, .param_sector_at_top,
  .protect_from_bottom, .protect_level_bits, .protect_base, .protect_size);

// file: test/fscp_host.sv
/* Host pin model: chip select frames with a link clock, write-protect
   and array result levels. The bench calls its tasks. */
`timescale 1ns/1ps
module fscp_host (
  // system
  input wire clk,
  // flash pins and results
  output reg chip_select_n_pin = 1'b1,
  output reg write_protect_n_pin = 1'b1,
  output reg erase_fail_in = 1'b0,
  output reg prog_fail_in = 1'b0
);
  // link clock stands low between frames
  reg sck = 1'b0;
  task frame(input integer n);
    integer i;
    begin
      #1 chip_select_n_pin = 1'b0;
      for (i = 0; i < 2 * n; i = i + 1)
        #40 sck = ~sck;
      #40 chip_select_n_pin = 1'b1;
    end
  endtask
  task pins(input wp, input ef, input pf);
    begin
      @(posedge clk);
      {write_protect_n_pin, erase_fail_in, prog_fail_in} <= {wp, ef, pf};
    end
  endtask
endmodule // fscp_host

// file: test/test_flash_status_config_protect.sv
/* Bench of the flash register bank over Wishbone.
   Assumes fscp_defines.vh on the include path. */
`timescale 1ns/1ps
`include "fscp_defines.vh"
module test_flash_status_config_protect;
  localparam [3:0] ST = `FSCP_ADR_STATUS;
  localparam [3:0] CF = `FSCP_ADR_CONFIG;
  reg clk = 1'b0;
  reg rst = 1'b1;
  reg cyc = 1'b0;
  reg stb = 1'b0;
  reg we = 1'b0;
  reg e;
  reg [3:0] adr = 4'h0;
  reg [7:0] q;
  reg [31:0] wdat = 32'h0;
  wire [31:0] rdat;
  wire ack, err, cs_n, wp_n, ef, pf, quad, wpa, pa, ptop, pbot;
  wire [1:0] pwr;
  integer n_mismatch = 0;
  integer n_compared = 0;
  always #2 clk = ~clk;
  fscp_regs #(.OP_CYCLES(16'h0010)) dut (.clk(clk), .rst(rst), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .wb_err_o(err), .chip_select_n_pin(cs_n),
    .write_protect_n_pin(wp_n), .erase_fail_in(ef), .prog_fail_in(pf),
    .power_state(pwr), .quad_pinout(quad), .wp_pin_active(wpa), .pause_pin_active(pa),
    .param_sector_at_top(ptop), .protect_from_bottom(pbot), .protect_level_bits(),
    .protect_base(), .protect_size());
  fscp_host host (.clk(clk), .chip_select_n_pin(cs_n), .write_protect_n_pin(wp_n),
    .erase_fail_in(ef), .prog_fail_in(pf));
  task give_verdict;
    begin
      $display("compared %0d mismatched %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0)
        $display("Simulation passed");
      else
        $display("Simulation failed");
      $finish;
    end
  endtask
  task chk(input [47:0] nm, input [7:0] x, input [7:0] g);
    begin
      n_compared = n_compared + 1;
      if (g !== x) begin
        n_mismatch = n_mismatch + 1;
        $display("[ERR] %0s expected %h seen %h", nm, x, g);
      end
    end
  endtask
  task wb(input [3:0] a, input w, input [7:0] d);
    integer i;
    begin
      i = 0;
      @(posedge clk);
      {cyc, stb, we, adr, wdat} <= {2'b11, w, a, 24'h000000, d};
      // answer is looked at where it is settled, released at its rising edge
      @(negedge clk);
      while (ack !== 1'b1 && err !== 1'b1 && i < 20) begin
        i = i + 1;
        @(negedge clk);
      end
      q = rdat[7:0];
      e = err;
      @(posedge clk);
      {cyc, stb} <= 2'b00;
      if (i == 20) begin
        chk("ack", 8'h01, 8'h00);
        give_verdict;
      end
    end
  endtask
  task cmd(input [3:0] c);
    wb(`FSCP_ADR_CMD, 1'b1, {4'h0, c});
  endtask
  // polls status until busy drops, leaves the last status in q
  task idle;
    integer i;
    begin
      i = 0;
      wb(ST, 1'b0, 8'h00);
      while (q[0] !== 1'b0 && i < 40) begin
        i = i + 1;
        wb(ST, 1'b0, 8'h00);
      end
      if (i == 40) begin
        chk("busy", 8'h00, 8'h01);
        give_verdict;
      end
    end
  endtask
  task wrreg(input [3:0] a, input [7:0] d);
    begin
      cmd(`FSCP_CMD_WRITE_ENABLE_COMMAND);
      wb(a, 1'b1, d);
      idle;
    end
  endtask
  task t_status;
    begin
      wb(CF, 1'b0, 8'h00);
      chk("config", 8'h00, q);
      wb(4'h2, 1'b0, 8'h00);
      chk("err", 8'h01, {7'h0, e});
      cmd(`FSCP_CMD_WRITE_ENABLE_COMMAND);
      idle;
      chk("status", 8'h02, q);
      cmd(`FSCP_CMD_WRDI);
      idle;
      chk("status", 8'h00, q);
      cmd(`FSCP_CMD_WRITE_ENABLE_COMMAND);
      wb(ST, 1'b1, 8'h84);
      wb(ST, 1'b0, 8'h00);
      chk("busy", 8'h01, q & 8'h01);
      chk("power", 8'h01, {6'h0, pwr});
      idle;
      chk("status", 8'h84, q);
      chk("power", 8'h00, {6'h0, pwr});
      host.pins(1'b0, 1'b0, 1'b0);
      wrreg(ST, 8'h08);
      chk("locked", 8'h21, {2'h0, q[7:2]});
      host.pins(1'b1, 1'b0, 1'b0);
      wrreg(ST, 8'h04);
      chk("status", 8'h04, q);
      $display("status test done");
    end
  endtask
  task t_config;
    begin
      wrreg(CF, 8'h2E);
      wb(CF, 1'b0, 8'h00);
      chk("config", 8'h2E, q);
      chk("pins", 8'h04, {5'h0, quad, wpa, pa});
      chk("ends", 8'h03, {6'h0, ptop, pbot});
      wrreg(CF, 8'h00);
      wb(CF, 1'b0, 8'h00);
      chk("config", 8'h2C, q);
      chk("pins", 8'h03, {5'h0, quad, wpa, pa});
      wrreg(CF, 8'h2D);
      wrreg(ST, 8'h18);
      chk("status", 8'h04, q);
      wrreg(CF, 8'h2C);
      wb(CF, 1'b0, 8'h00);
      chk("config", 8'h2D, q);
      $display("config test done");
    end
  endtask
  task t_power;
    begin
      fork
        host.frame(8);
        begin
          repeat (40) @(posedge clk);
          chk("power", 8'h01, {6'h0, pwr});
        end
      join
      cmd(`FSCP_CMD_SLEEP);
      wrreg(`FSCP_ADR_CMD, {4'h0, `FSCP_CMD_PROG});
      chk("power", 8'h02, {6'h0, pwr});
      cmd(`FSCP_CMD_WAKE);
      host.pins(1'b1, 1'b1, 1'b0);
      wrreg(`FSCP_ADR_CMD, {4'h0, `FSCP_CMD_ERASE});
      chk("status", 8'h24, q);
      host.pins(1'b1, 1'b0, 1'b1);
      wrreg(`FSCP_ADR_CMD, {4'h0, `FSCP_CMD_PROG});
      chk("perr", 8'h40, q & 8'h40);
      $display("power test done");
    end
  endtask
  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    t_status;
    t_config;
    t_power;
    give_verdict;
  end
endmodule // test_flash_status_config_protect
